// file: verilog/pac_pkg.sv
// Package with register map, field layout and types of the PWM aux control.
// Function
// - Period fine disable bit 15 stops fine period
// - Duty fine disable bit 14 stops fine duty
// - Blank source bits 11:8 mask fault, limit
// - Blank code 0 none, 1-5 generator highs
// - Codes 0110 to 1111 are reserved
// - Chop source bits 5:2 chop enabled outputs
// - Chop code 0 internal clock, 1-5 highs
// - Bit 1 enables high side chopping
// - Bit 0 enables low side chopping
// - Bits 13:12, 7:6 ignore writes, read zero
// - Implemented fields read/write, reset to zero
package pac_pkg;

   // Register byte offsets on the APB.
   localparam logic [11:0] PAC_OFS_CTRL = 12'h000;
   localparam logic [11:0] PAC_OFS_LEB = 12'h004;
   localparam logic [11:0] PAC_OFS_STAT = 12'h008;

   // Field positions in the auxiliary control word.
   localparam int PAC_FINE_PER_BIT = 15;
   localparam int PAC_FINE_DUTY_BIT = 14;
   localparam int PAC_BLANK_LSB = 8;
   localparam int PAC_CHOP_LSB = 2;
   localparam int PAC_CHOP_H_BIT = 1;
   localparam int PAC_CHOP_L_BIT = 0;
   localparam int PAC_SEL_W = 4;

   // Field positions in the blanking enable register.
   localparam int PAC_LEB_H_BIT = 1;
   localparam int PAC_LEB_L_BIT = 0;

   // Writable bits of the control word and of the blanking register.
   localparam logic [15:0] PAC_CTRL_WMASK = 16'hcf3f;
   localparam logic [1:0] PAC_LEB_WMASK = 2'h3;

   // Reset values.
   localparam logic [15:0] PAC_CTRL_RST = 16'h0000;
   localparam logic [1:0] PAC_LEB_RST = 2'h0;

   // Number of sibling generators and highest legal select code.
   localparam int PAC_NSRC = 5;
   localparam logic [3:0] PAC_SEL_MAX = 4'h5;

   // Internal chop clock: half period in ns, and in cycles of 50 ns.
   localparam int PAC_CLK_PERIOD_NS = 50;
   localparam int PAC_CHOP_HALF_NS = 1000;
   localparam int PAC_CHOP_HALF_CYC =
      (PAC_CHOP_HALF_NS / PAC_CLK_PERIOD_NS > 0) ?
      PAC_CHOP_HALF_NS / PAC_CLK_PERIOD_NS : 1;
   localparam int PAC_DIV_W = 5;

   // APB request as driven by the master.
   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pac_apb_req_s;

   // APB answer of the slave.
   typedef struct packed
   {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pac_apb_rsp_s;

   // Raw signals of this channel's generator and protection logic.
   typedef struct packed
   {
      logic high;
      logic low;
      logic fault;
      logic climit;
   } pac_gen_s;

   // Whole state of the top module.
   typedef struct packed
   {
      logic [15:0] ctrl;
      logic [1:0] leb;
      logic chop_clk;
      logic [PAC_DIV_W-1:0] div;
      pac_apb_rsp_s rsp;
      logic high_out;
      logic low_out;
      logic fault_out;
      logic climit_out;
      logic fine_per_en;
      logic fine_duty_en;
   } pac_state_s;

endpackage

// file: verilog/pac_src_sel.sv
// Source selector that picks one sibling high output by a 4-bit code.
`timescale 1ns/10ps
module pac_src_sel
   import pac_pkg::*;
(
   input wire logic [3:0] code,
   input wire logic [PAC_NSRC-1:0] src,
   input wire logic dflt,
   output logic sel,
   output logic rsvd
);
   logic [PAC_NSRC-1:0] hit;

   // One match term per sibling generator, code n picks generator n.
   genvar gi;
   generate
      for (gi = 0; gi < PAC_NSRC; gi = gi + 1)
      begin : g_src
         assign hit[gi] = (code == 4'(gi + 1)) & src[gi];
      end
   endgenerate

   // Code zero gives the default; reserved codes select nothing at all.
   always_comb
   begin
      sel = (|hit) | ((code == 4'h0) & dflt);
      rsvd = (code > PAC_SEL_MAX);
   end
endmodule

// file: verilog/pac_top.sv
// Auxiliary control of one PWM channel: blanking, chopping, fine disables.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
module pac_top
   import pac_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire pac_pkg::pac_apb_req_s APB_REQ,
   output pac_pkg::pac_apb_rsp_s APB_RSP,
   input wire logic [pac_pkg::PAC_NSRC-1:0] SIB_HIGH,
   input wire pac_pkg::pac_gen_s GEN_IN,
   output logic CHANNEL_HIGH_OUTPUT,
   output logic CHANNEL_LOW_OUTPUT,
   output logic FAULT_OUT,
   output logic CLIMIT_OUT,
   output logic FINE_PERIOD_EN,
   output logic FINE_DUTY_EN
);
   import pac_pkg::*;

   pac_state_s st_q;
   pac_state_s st_d;

   logic setup_cyc;
   logic access_cyc;
   logic blank_sig;
   logic chop_sig;
   logic blank_rsvd;
   logic chop_rsvd;
   logic blank_mask;

   logic [3:0] blank_code;
   logic [3:0] chop_code;
   logic chop_h_en;
   logic chop_l_en;

   // Field views of the stored control word.
   assign blank_code = st_q.ctrl[PAC_BLANK_LSB +: PAC_SEL_W];
   assign chop_code = st_q.ctrl[PAC_CHOP_LSB +: PAC_SEL_W];
   assign chop_h_en = st_q.ctrl[PAC_CHOP_H_BIT];
   assign chop_l_en = st_q.ctrl[PAC_CHOP_L_BIT];

   // APB phases; the access only counts once our ready is up.
   assign setup_cyc = APB_REQ.psel & ~APB_REQ.penable;
   assign access_cyc = APB_REQ.psel & APB_REQ.penable & st_q.rsp.pready;

   // State blank source; code zero means no blanking at all.
   pac_src_sel u_blank_sel
   (
      .code(blank_code),
      .src(SIB_HIGH),
      .dflt(1'b0),
      .sel(blank_sig),
      .rsvd(blank_rsvd)
   );

   // Chop source; code zero takes the internal chop clock.
   pac_src_sel u_chop_sel
   (
      .code(chop_code),
      .src(SIB_HIGH),
      .dflt(st_q.chop_clk),
      .sel(chop_sig),
      .rsvd(chop_rsvd)
   );

   // Blanking applies only where a side enable in the blank register is set.
   assign blank_mask = blank_sig & (|st_q.leb);

   // Next state: bus slave, chop divider and registered outputs.
   always_comb
   begin
      st_d = st_q;

      // Answer is prepared in the setup cycle so pready comes from a flop.
      st_d.rsp.pready = setup_cyc;
      st_d.rsp.pslverr = 1'b0;
      st_d.rsp.prdata = 32'h0000_0000;
      if (setup_cyc)
      begin
         case (APB_REQ.paddr)
            PAC_OFS_CTRL:
            begin
               // Unimplemented bits read as zero.
               st_d.rsp.prdata[15:0] = st_q.ctrl & PAC_CTRL_WMASK;
            end
            PAC_OFS_LEB:
            begin
               st_d.rsp.prdata[1:0] = st_q.leb;
            end
            PAC_OFS_STAT:
            begin
               st_d.rsp.prdata[5:0] = {chop_rsvd, blank_rsvd,
                                       st_q.low_out, st_q.high_out,
                                       chop_sig, blank_mask};
            end
            default:
            begin
               st_d.rsp.pslverr = 1'b1;
            end
         endcase
      end

      // Writes land at the completing edge; the status word is read only.
      if (access_cyc && APB_REQ.pwrite && !st_q.rsp.pslverr)
      begin
         case (APB_REQ.paddr)
            PAC_OFS_CTRL:
            begin
               st_d.ctrl = APB_REQ.pwdata[15:0] & PAC_CTRL_WMASK;
            end
            PAC_OFS_LEB:
            begin
               st_d.leb = APB_REQ.pwdata[1:0] & PAC_LEB_WMASK;
            end
            default:
            begin
               st_d.ctrl = st_q.ctrl;
            end
         endcase
      end

      // Internal chop clock: toggles every half period while running free.
      if (st_q.div == PAC_DIV_W'(PAC_CHOP_HALF_CYC - 1))
      begin
         st_d.div = '0;
         st_d.chop_clk = ~st_q.chop_clk;
      end
      else
      begin
         st_d.div = st_q.div + PAC_DIV_W'(1);
      end

      // Chopping gates an output with the chosen source only when enabled.
      // A reserved chop code yields a low source, so chopped outputs stay
      // off rather than running unchopped into a bridge.
      st_d.high_out = GEN_IN.high & (~chop_h_en | chop_sig);
      st_d.low_out = GEN_IN.low & (~chop_l_en | chop_sig);

      // Fault and current-limit inputs are hidden while blanking is active.
      st_d.fault_out = GEN_IN.fault & ~blank_mask;
      st_d.climit_out = GEN_IN.climit & ~blank_mask;

      // Fine-resolution enables are the inverse of the disable fields.
      st_d.fine_per_en = ~st_q.ctrl[PAC_FINE_PER_BIT];
      st_d.fine_duty_en = ~st_q.ctrl[PAC_FINE_DUTY_BIT];
   end

   // Single state register with synchronous reset.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         st_q <= '0;
         st_q.ctrl <= PAC_CTRL_RST;
         st_q.leb <= PAC_LEB_RST;
         st_q.fine_per_en <= 1'b1;
         st_q.fine_duty_en <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Every output is a flop of the state.
   assign APB_RSP = st_q.rsp;
   assign CHANNEL_HIGH_OUTPUT = st_q.high_out;
   assign CHANNEL_LOW_OUTPUT = st_q.low_out;
   assign FAULT_OUT = st_q.fault_out;
   assign CLIMIT_OUT = st_q.climit_out;
   assign FINE_PERIOD_EN = st_q.fine_per_en;
   assign FINE_DUTY_EN = st_q.fine_duty_en;

   // Checks on the behaviour above, all in the system clock domain.
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);

   localparam int HALF_CYC = PAC_CHOP_HALF_CYC;

   // A completed write to the control word.
   sequence s_ctrl_write;
      access_cyc && APB_REQ.pwrite && APB_REQ.paddr == PAC_OFS_CTRL;
   endsequence

   // A completed read of the control word.
   sequence s_ctrl_read;
      APB_REQ.psel && APB_REQ.penable && st_q.rsp.pready &&
      !APB_REQ.pwrite && APB_REQ.paddr == PAC_OFS_CTRL;
   endsequence

   // The period fine enable follows the written bit two edges later.
   property p_fine_per;
      logic b;
      (s_ctrl_write, b = APB_REQ.pwdata[PAC_FINE_PER_BIT])
      ##1 !access_cyc |-> ##1 FINE_PERIOD_EN == !b;
   endproperty
   AST_FINE_PERIOD: assert property (p_fine_per)
      else $error("Fine period enable does not follow its disable bit.");

   AST_FINE_DUTY: assert property (
      FINE_DUTY_EN == !$past(st_q.ctrl[PAC_FINE_DUTY_BIT]))
      else $error("Fine duty enable does not follow its disable bit.");

   AST_UNIMPL_ZERO: assert property (
      s_ctrl_read |-> APB_RSP.prdata[13:12] == 2'h0 &&
      APB_RSP.prdata[7:6] == 2'h0 && APB_RSP.prdata[31:16] == 16'h0)
      else $error("Unimplemented control bits read back nonzero.");

   AST_RESET_ZERO: assert property (
      $past(!RSTN) |-> st_q.ctrl == 16'h0000 && FINE_PERIOD_EN)
      else $error("Control word not cleared by reset.");

   AST_WRITE_READ: assert property (
      s_ctrl_write |=> st_q.ctrl == ($past(APB_REQ.pwdata[15:0]) & 16'hcf3f))
      else $error("Control word write not stored as written.");

   AST_NO_BLANK: assert property (
      blank_code == 4'h0 |=> FAULT_OUT == $past(GEN_IN.fault) &&
      CLIMIT_OUT == $past(GEN_IN.climit))
      else $error("Fault input masked with no blank source chosen.");

   AST_BLANK_MASK: assert property (
      blank_code == 4'h1 && st_q.leb != 2'h0 && SIB_HIGH[0]
      |=> !FAULT_OUT && !CLIMIT_OUT)
      else $error("Fault input passed while blank source was high.");

   AST_BLANK_OFF: assert property (
      st_q.leb == 2'h0 |=> FAULT_OUT == $past(GEN_IN.fault))
      else $error("Fault masked while both side blank enables are clear.");

   AST_NO_CHOP_H: assert property (
      !chop_h_en |=> CHANNEL_HIGH_OUTPUT == $past(GEN_IN.high))
      else $error("High output altered with chopping disabled.");

   AST_CHOP_L_SRC: assert property (
      chop_l_en && chop_code == 4'h3
      |=> CHANNEL_LOW_OUTPUT == $past(GEN_IN.low && SIB_HIGH[2]))
      else $error("Low output not chopped by the chosen sibling.");

   AST_CHOP_GATE: assert property (
      chop_h_en && !chop_sig |=> !CHANNEL_HIGH_OUTPUT)
      else $error("Chopped high output active while source low.");

   AST_CHOP_INT: assert property (
      chop_code == 4'h0 |-> chop_sig == st_q.chop_clk)
      else $error("Chop code zero does not pick the internal clock.");

   AST_CHOP_PERIOD: assert property (
      $changed(st_q.chop_clk) |-> st_q.div == 5'h0 ##1
      $stable(st_q.chop_clk) [*2])
      else $error("Internal chop clock toggles off its half period.");

   AST_DIV_RANGE: assert property (
      int'(st_q.div) < HALF_CYC)
      else $error("Chop divider left its range.");

   AST_RSVD_CHOP: assert property (
      chop_h_en && chop_code > 4'h5 |=> !CHANNEL_HIGH_OUTPUT)
      else $error("Reserved chop code let the high output through.");

   AST_RSVD_BLANK: assert property (
      blank_code > 4'h5 |=> FAULT_OUT == $past(GEN_IN.fault))
      else $error("Reserved blank code masked the fault input.");

   AST_READY_PULSE: assert property (
      APB_RSP.pready |=> !APB_RSP.pready)
      else $error("Ready held longer than one access cycle.");

   // A completed write to the blanking enable register.
   sequence s_leb_write;
      access_cyc && APB_REQ.pwrite && APB_REQ.paddr == PAC_OFS_LEB;
   endsequence

   // The duty fine enable follows its written bit two edges later.
   property p_fine_duty;
      logic b;
      (s_ctrl_write, b = APB_REQ.pwdata[PAC_FINE_DUTY_BIT])
      ##1 !access_cyc |-> ##1 FINE_DUTY_EN == !b;
   endproperty
   AST_FINE_DUTY_WR: assert property (p_fine_duty)
      else $error("Fine duty enable does not follow a written bit.");

   AST_LEB_WRITE: assert property (
      s_leb_write |=> st_q.leb == $past(APB_REQ.pwdata[1:0]))
      else $error("Blank enable write not stored as written.");

   AST_BLANK_SRC5: assert property (
      blank_code == 4'h5 && st_q.leb != 2'h0 && SIB_HIGH[4]
      |=> !FAULT_OUT && !CLIMIT_OUT)
      else $error("Fifth sibling high did not blank the fault input.");

   // A low blank source must let the protection inputs through.
   AST_BLANK_SRC_LOW: assert property (
      blank_code == 4'h2 && !SIB_HIGH[1]
      |=> CLIMIT_OUT == $past(GEN_IN.climit))
      else $error("Current limit masked while blank source was low.");

   AST_RSVD_CLIMIT: assert property (
      blank_code > 4'h5 |=> CLIMIT_OUT == $past(GEN_IN.climit))
      else $error("Reserved blank code masked the current limit.");

   AST_RSVD_CHOP_L: assert property (
      chop_l_en && chop_code > 4'h5 |=> !CHANNEL_LOW_OUTPUT)
      else $error("Reserved chop code let the low output through.");

   AST_CHOP_H_SRC: assert property (
      chop_h_en && chop_code == 4'h5
      |=> CHANNEL_HIGH_OUTPUT == $past(GEN_IN.high && SIB_HIGH[4]))
      else $error("High output not chopped by the chosen sibling.");

   AST_NO_CHOP_L: assert property (
      !chop_l_en |=> CHANNEL_LOW_OUTPUT == $past(GEN_IN.low))
      else $error("Low output altered with chopping disabled.");

   // Low side on the internal clock: the gate must follow its phase.
   AST_CHOP_INT_L: assert property (
      chop_l_en && chop_code == 4'h0
      |=> CHANNEL_LOW_OUTPUT == $past(GEN_IN.low && st_q.chop_clk))
      else $error("Low output not chopped by the internal clock.");

   AST_CHOP_GATE_L: assert property (
      chop_l_en && !chop_sig |=> !CHANNEL_LOW_OUTPUT)
      else $error("Chopped low output active while source low.");

   AST_CHOP_PASS: assert property (
      chop_h_en && chop_sig && GEN_IN.high |=> CHANNEL_HIGH_OUTPUT)
      else $error("Chopped high output held off while source high.");

   // The chop clock moves only at the end of a half period.
   AST_CHOP_STEADY: assert property (
      int'(st_q.div) != HALF_CYC - 1 |=> $stable(st_q.chop_clk))
      else $error("Internal chop clock toggled inside a half period.");

   AST_CHOP_TOGGLE: assert property (
      int'(st_q.div) == HALF_CYC - 1 |=> $changed(st_q.chop_clk))
      else $error("Internal chop clock missed the end of a half period.");

   // Control bits move only on a completed write to their address.
   AST_CTRL_HOLD: assert property (
      !(access_cyc && APB_REQ.pwrite && APB_REQ.paddr == PAC_OFS_CTRL)
      |=> $stable(st_q.ctrl))
      else $error("Control word changed without a write.");

   AST_STAT_RO: assert property (
      access_cyc && APB_REQ.pwrite && APB_REQ.paddr == PAC_OFS_STAT
      |=> $stable(st_q.ctrl) && $stable(st_q.leb))
      else $error("Status write changed a control register.");

   AST_UNIMPL_STORE: assert property (
      s_ctrl_write |=> st_q.ctrl[13:12] == 2'h0 && st_q.ctrl[7:6] == 2'h0)
      else $error("Unimplemented control bits took a written one.");

   // Outside an access the read bus idles at zero with no error.
   AST_IDLE_ZERO: assert property (
      !APB_RSP.pready |-> APB_RSP.prdata == 32'h0 && !APB_RSP.pslverr)
      else $error("Read bus not idle outside an access.");

endmodule

// file: dv/pac_sib_model.sv
// Partner model: sibling high outputs and this channel's raw signals.
`timescale 1ns/10ps
module pac_sib_model
   import pac_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   output logic [pac_pkg::PAC_NSRC-1:0] sib,
   output pac_pkg::pac_gen_s gen
);
   import pac_pkg::*;
   logic [15:0] lfsr_q;

   // A pseudo-random walk changes the siblings nearly every cycle, so a
   // stale or wrong source pick shows up at once instead of hiding.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         lfsr_q <= 16'hace1;
      end
      else
      begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                    ^ lfsr_q[10]};
      end
   end

   // Levels only; the block samples them on the same clock.
   assign sib = lfsr_q[4:0] ^ lfsr_q[12:8];
   assign gen = pac_gen_s'(lfsr_q[15:12] ^ lfsr_q[6:3]);
endmodule

// file: dv/testbench.sv
// Self-checking testbench of the PWM auxiliary control block.
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module testbench;
   import pac_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   pac_apb_req_s req = '0;
   pac_apb_rsp_s rsp;
   logic [4:0] sib;
   pac_gen_s gen;
   wire [5:0] outs;
   logic [15:0] ctrl_sh = '0;
   logic [1:0] leb_sh = '0;
   logic [11:0] dq[$];
   logic [32:0] aq[$];
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int chop_cnt = 0;
   logic chop_ref = 1'b0;

   pac_top pac_top_inst (
      .CLK_SYS(clk_sys),
      .RSTN(rstn),
      .APB_REQ(req),
      .APB_RSP(rsp),
      .SIB_HIGH(sib),
      .GEN_IN(gen),
      .CHANNEL_HIGH_OUTPUT(outs[5]),
      .CHANNEL_LOW_OUTPUT(outs[4]),
      .FAULT_OUT(outs[3]),
      .CLIMIT_OUT(outs[2]),
      .FINE_PERIOD_EN(outs[1]),
      .FINE_DUTY_EN(outs[0])
   );

   pac_sib_model pac_sib_model_inst (
      .clk(clk_sys),
      .rstn(rstn),
      .sib(sib),
      .gen(gen)
   );

   always #25 clk_sys = ~clk_sys;

   // Expected outputs as {mask, value}; the internal chop clock restarts
   // with every reset, so the bench mirrors it and checks every output.
   function automatic logic [11:0] expect_out();
      logic [3:0] bc;
      logic [3:0] cc;
      logic bm;
      logic cs;
      logic [5:0] m;
      bc = ctrl_sh[11:8];
      cc = ctrl_sh[5:2];
      bm = (bc >= 4'h1 && bc <= 4'h5) ? sib[bc - 4'h1] & (leb_sh != 2'h0)
         : 1'b0;
      cs = (cc >= 4'h1 && cc <= 4'h5) ? sib[cc - 4'h1] : 1'b0;
      if (cc == 4'h0)
         cs = chop_ref;
      m = 6'h3f;
      if (!rstn)
         return {6'h3f, 6'h03};
      return {m, m & {gen.high & (cs | ~ctrl_sh[1]),
         gen.low & (cs | ~ctrl_sh[0]), gen.fault & ~bm, gen.climit & ~bm,
         ~ctrl_sh[15], ~ctrl_sh[14]}};
   endfunction

   // Notes what the next edge must produce, and cuts a hang short.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         errors++;
         test_done();
      end
      dq.push_back(expect_out());
      // Mirror the free-running chop clock, restarted by every reset.
      if (!rstn)
      begin
         chop_cnt = 0;
         chop_ref = 1'b0;
      end
      else if (chop_cnt == PAC_CHOP_HALF_CYC - 1)
      begin
         chop_cnt = 0;
         chop_ref = ~chop_ref;
      end
      else
      begin
         chop_cnt++;
      end
   end

   // Compares settled outputs with the oldest notes.
   always @(negedge clk_sys)
   begin
      logic [11:0] e;
      logic [32:0] a;
      if (dq.size() > 0)
      begin
         e = dq.pop_front();
         `CHK(outs & e[11:6], e[5:0])
      end
      if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && aq.size() > 0)
      begin
         a = aq.pop_front();
         `CHK({rsp.pslverr, rsp.prdata}, a)
      end
   end

   // One APB transfer; entered just after a rising edge.
   task automatic apb(input logic wr, input logic [11:0] ad,
                      input logic [31:0] d, input logic [32:0] exp);
      if (!wr)
         aq.push_back(exp);
      req.psel <= 1'b1;
      req.pwrite <= wr;
      req.paddr <= ad;
      req.pwdata <= d;
      @(posedge clk_sys);
      req.penable <= 1'b1;
      // Wait for the answer however long; only the bench timeout ends it.
      do
      begin
         @(posedge clk_sys);
      end
      while (rsp.pready !== 1'b1);
      if (wr && ad == PAC_OFS_CTRL)
         ctrl_sh <= d[15:0] & PAC_CTRL_WMASK;
      if (wr && ad == PAC_OFS_LEB)
         leb_sh <= d[1:0];
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      logic [31:0] w;
      void'($urandom(55713));
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      apb(1'b0, PAC_OFS_CTRL, 32'h0, 33'h0);
      apb(1'b0, PAC_OFS_LEB, 32'h0, 33'h0);
      $display("reset test done");
      // Unimplemented bits must read back zero after writing all ones.
      apb(1'b1, PAC_OFS_CTRL, 32'hffffffff, 33'h0);
      apb(1'b0, PAC_OFS_CTRL, 32'h0, {17'h0, PAC_CTRL_WMASK});
      apb(1'b1, 12'h00c, 32'h0, 33'h0);
      apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
      apb(1'b0, PAC_OFS_CTRL, 32'h0, {17'h0, PAC_CTRL_WMASK});
      apb(1'b1, PAC_OFS_LEB, 32'hffffffff, 33'h0);
      apb(1'b0, PAC_OFS_LEB, 32'h0, 33'h3);
      // Reserved codes on both selects with both chop enables set.
      apb(1'b1, PAC_OFS_CTRL, 32'h0000061f, 33'h0);
      // The status word ignores writes and shows both reserved flags.
      apb(1'b1, PAC_OFS_STAT, 32'hffffffff, 33'h0);
      apb(1'b0, PAC_OFS_STAT, 32'h0, 33'h30);
      apb(1'b0, PAC_OFS_CTRL, 32'h0, 33'h61f);
      $display("register test done");
      // Blank and chop codes 0 to 9, legal and reserved, with random rest.
      for (int b = 0; b < 10; b++)
      begin
         for (int c = 0; c < 10; c++)
         begin
            w = $urandom;
            w[11:8] = b[3:0];
            w[5:2] = c[3:0];
            apb(1'b1, PAC_OFS_CTRL, w, 33'h0);
            apb(1'b1, PAC_OFS_LEB, $urandom, 33'h0);
            repeat (6) @(posedge clk_sys);
         end
      end
      $display("select test done");
      test_done();
   end
endmodule
